//--- hdl/ann_trunk_pkg.sv
// Package: constants, field layouts and types of the announcement trunk
package ann_trunk_pkg;

    ////////////////////////////////////////////////////////////////////
    // Clock and time base
    localparam int CLK_PERIOD_NS = 25;
    localparam int MS_NS = 1000000;
    localparam int TICK_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
    localparam int TICK_W = 16;

    ////////////////////////////////////////////////////////////////////
    // Pulse timing in milliseconds
    localparam int PW_W = 9;
    localparam logic [PW_W-1:0] PULSE_NOM_MS = 9'd250;
    localparam logic [PW_W-1:0] PULSE_TOL_MS = 9'd50;
    localparam logic [PW_W-1:0] PULSE_MIN_MS = PULSE_NOM_MS - PULSE_TOL_MS;
    localparam logic [PW_W-1:0] PULSE_MAX_MS = PULSE_NOM_MS + PULSE_TOL_MS;
    localparam logic [PW_W-1:0] START_PULSE_MS = PULSE_NOM_MS;
    localparam logic [PW_W-1:0] LEVEL_GAP_MS = 9'd10;
    localparam logic [PW_W-1:0] PW_SAT = '1;

    // Longest message is two hours
    localparam int DUR_W = 23;
    localparam logic [DUR_W-1:0] MAX_PLAY_MS = 23'd7200000;

    ////////////////////////////////////////////////////////////////////
    // Register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_CMD = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_DUR = 4'hc;

    localparam int CMD_REQ_BIT = 0;
    localparam int CMD_REL_BIT = 1;
    localparam int CMD_SEIZE_BIT = 2;
    localparam int CMD_UNSEIZE_BIT = 3;
    localparam int CMD_CLR_ERR_BIT = 4;

    ////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        MODE_CONT, MODE_PULSE, MODE_LEVEL, MODE_RSVD
    } mode_t;

    typedef enum logic [1:0] {
        ST_IDLE, ST_WAIT, ST_PLAY, ST_RESTART
    } state_t;

    typedef struct packed {
        logic [3:0] rep_limit;
        logic icpt_ok;
        logic barge;
        logic gnd_play;
        logic multi;
        mode_t mode;
    } ctrl_t;

    localparam int CTRL_W = $bits(ctrl_t);
    localparam ctrl_t CTRL_RST = '{
        rep_limit: 4'h3, icpt_ok: 1'b0, barge: 1'b0,
        gnd_play: 1'b0, multi: 1'b0, mode: MODE_CONT};

    typedef struct packed {
        logic [3:0] rep;
        state_t state;
        logic avail;
        logic answered;
        logic seized;
        logic bad_pulse;
        logic connected;
    } stat_t;

endpackage : ann_trunk_pkg

//--- hdl/pulse_qual.sv
// Width qualifier for the announcer control-line pulses
`timescale 1ns/1ps
module pulse_qual
    import ann_trunk_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Time base and line
    input wire logic tick_i,
    input wire logic line_i,
    // Verdict at the trailing edge
    output logic ok_o,
    output logic bad_o
);

    logic line_d_r;
    logic [PW_W-1:0] width_r;
    logic fall;
    logic in_win;

    assign fall = line_d_r && !line_i;
    assign in_win = (width_r >= PULSE_MIN_MS) && (width_r <= PULSE_MAX_MS);

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            line_d_r <= 1'b0;
        end else begin
            line_d_r <= line_i;
        end
    end

    // Saturates so a stuck line cannot wrap into the window
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            width_r <= '0;
        end else if (line_i && !line_d_r) begin
            width_r <= '0;
        end else if (line_i && tick_i && width_r != PW_SAT) begin
            width_r <= width_r + 1'b1; // see R22
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ok_o <= 1'b0;
            bad_o <= 1'b0;
        end else begin
            ok_o <= fall && in_win; // see R22
            bad_o <= fall && !in_win;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    chk_pulse_window: assert property ( // see R22
        @(posedge mclk_i) disable iff (reset_i)
        ok_o |-> $past(width_r) >= PULSE_MIN_MS
                 && $past(width_r) <= PULSE_MAX_MS)
        else $error("pulse accepted outside width window");

endmodule : pulse_qual

//--- hdl/announcement_trunk_control.sv
// Announcement trunk unit: start drive, cut-through, repeats, seizure
// Function
// R1: Outgoing seizure puts battery on tip and ground on ring.
// R2: Far end answers seizure with a low-resistance loop across tip/ring.
// R3: Continuous announcer replays endlessly without any start request.
// R4: Continuous announcer start line is tied permanently to ground.
// R5: Announcer pulses about 250 ms at message end; trunk cuts through.
// R6: Continuous mode supports both barge-in and ringback until restart.
// R7: Announcer grounds availability only when recorded and online.
// R8: Start modes ignore availability; trunk output drives announcer start.
// R9: Pulse start plays the message through to its end.
// R10: Pulse start ignores further start pulses during playback.
// R11: Level start plays from leading edge until trailing edge or end.
// R12: Message cut short by level removal is reset for replay.
// R13: Start modes also pulse about 250 ms at message start.
// R14: Up to 24 trunks share one channel's start and end lines.
// R15: Multi-channel trunks own one channel each and act independently.
// R16: Multi-channel modes never bridge trunks onto one channel.
// R17: Play tracking handles two-hour announcements without overflow.
// R18: Setting picks whether announcer ground means play or idle.
// R19: Count repeats; at limit force disconnect or attendant intercept.
// R20: Setting picks the point where a waiting call joins.
// R21: Each trunk is set to exactly one announcer mode.
// R22: Timing from a millisecond tick; pulses width-checked with tolerance.
`timescale 1ns/1ps
module announcement_trunk_control
    import ann_trunk_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Register port
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    // Trunk control line, two-way: availability in, start out
    input wire logic trunk_ctl_i,
    output logic trunk_ctl_o,
    output logic trunk_ctl_oe_o,
    // Announcer message pulse line, 1 = ground
    input wire logic msg_gnd_i,
    // Outgoing seizure
    input wire logic loop_i,
    output logic tip_batt_o,
    // Call path
    output logic connect_o,
    output logic ringback_o,
    output logic disc_o,
    output logic icpt_o
);

    ////////////////////////////////////////////////////////////////////
    // Declarations
    ctrl_t ctrl_r;
    ctrl_t ctrl_nxt;
    state_t state_r;
    logic [TICK_W-1:0] tick_cnt_r;
    logic tick;
    logic [3:0] rep_r;
    logic [PW_W-1:0] timer_r;
    logic [DUR_W-1:0] dur_r;
    logic start_r;
    logic start_nxt;
    logic own_r;
    logic seize_r;
    logic bad_r;
    logic disc_r;
    logic icpt_r;
    logic [DATA_W-1:0] rdata_r;
    logic cont;
    logic lvl;
    logic ctl_act;
    logic avail;
    logic qual_ok;
    logic qual_bad;
    logic rep_last;
    logic kick;
    logic wr_cmd;
    logic req_cmd;
    logic rel_cmd;
    stat_t stat;

    assign cont = ctrl_r.mode == MODE_CONT;
    assign lvl = ctrl_r.mode == MODE_LEVEL;
    assign wr_cmd = wr_i && addr_i == ADDR_CMD;
    assign req_cmd = wr_cmd && wdata_i[CMD_REQ_BIT];
    assign rel_cmd = wr_cmd && wdata_i[CMD_REL_BIT];

    ////////////////////////////////////////////////////////////////////
    // Millisecond time base
    assign tick = tick_cnt_r == TICK_W'(TICK_CYCLES - 1);

    always_ff @(posedge mclk_i) begin
        if (reset_i || tick) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 1'b1; // see R22
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Line sensing
    // Ground sense of the message line is software's choice
    assign ctl_act = ~(msg_gnd_i ^ ctrl_r.gnd_play); // see R18
    // Availability only counts in continuous mode, never while we drive
    assign avail = cont && !trunk_ctl_oe_o && trunk_ctl_i; // see R7, R8

    pulse_qual u_qual (
        .mclk_i (mclk_i),
        .reset_i(reset_i),
        .tick_i (tick),
        .line_i (ctl_act),
        .ok_o   (qual_ok),
        .bad_o  (qual_bad)
    );

    ////////////////////////////////////////////////////////////////////
    // Configuration
    always_comb begin
        ctrl_nxt = ctrl_t'(wdata_i[CTRL_W-1:0]);
        if (ctrl_nxt.mode == MODE_RSVD) begin
            ctrl_nxt.mode = ctrl_r.mode; // see R21
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ctrl_r <= CTRL_RST;
        end else if (wr_i && addr_i == ADDR_CTRL) begin
            ctrl_r <= ctrl_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Call state
    assign rep_last = ctrl_r.rep_limit != '0
                      && rep_r + 1'b1 == ctrl_r.rep_limit;
    assign kick = !rel_cmd && !cont
                  && ((state_r == ST_IDLE && req_cmd)
                      || (state_r == ST_PLAY && qual_ok && !rep_last));

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_r <= ST_IDLE;
            rep_r <= '0;
            disc_r <= 1'b0;
            icpt_r <= 1'b0;
        end else begin
            disc_r <= 1'b0;
            icpt_r <= 1'b0;
            if (rel_cmd) begin
                state_r <= ST_IDLE;
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        if (req_cmd) begin
                            rep_r <= '0;
                            // Barge-in joins mid-message; else ringback
                            if (ctrl_r.barge && avail) begin
                                state_r <= ST_PLAY; // see R6, R20
                            end else begin
                                state_r <= ST_WAIT;
                            end
                        end
                    end
                    ST_WAIT: begin
                        if (cont) begin
                            if (qual_ok && avail) begin
                                state_r <= ST_PLAY; // see R5, R6
                            end
                        end else if (qual_ok && (own_r || !ctrl_r.multi)) begin
                            // Shared line: another unit's start also serves
                            state_r <= ST_PLAY; // see R13, R14, R16
                        end
                    end
                    ST_PLAY: begin
                        if (qual_ok) begin
                            if (rep_last) begin
                                state_r <= ST_IDLE;
                                icpt_r <= ctrl_r.icpt_ok; // see R19
                                disc_r <= !ctrl_r.icpt_ok; // see R19
                            end else begin
                                rep_r <= rep_r + 1'b1; // see R19
                                if (!cont) begin
                                    state_r <= ST_RESTART; // see R9
                                end
                            end
                        end
                    end
                    ST_RESTART: begin
                        if (qual_ok) begin
                            state_r <= ST_PLAY;
                        end
                    end
                    default: begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Start drive
    // One timer serves as pulse length or as level re-arm gap
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            timer_r <= '0;
        end else if (kick) begin
            timer_r <= lvl ? LEVEL_GAP_MS : START_PULSE_MS;
        end else if (tick && timer_r != '0) begin
            timer_r <= timer_r - 1'b1; // see R22
        end
    end

    always_comb begin
        if (cont || state_r == ST_IDLE) begin
            start_nxt = 1'b0; // see R8
        end else if (lvl) begin
            // Dropping the level resets the message for the next call
            start_nxt = timer_r == '0 && !kick; // see R11, R12
        end else begin
            start_nxt = timer_r != '0; // see R9, R10
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            start_r <= 1'b0;
            own_r <= 1'b0;
        end else begin
            start_r <= start_nxt;
            // Multi-channel trunk trusts only pulses it provoked itself
            if (state_r == ST_IDLE) begin
                own_r <= 1'b0; // see R15
            end else if (start_r) begin
                own_r <= 1'b1;
            end
        end
    end

    // Grounds the start line only; open otherwise so 24 units can share it
    assign trunk_ctl_o = start_r; // see R14
    assign trunk_ctl_oe_o = start_r; // see R8

    ////////////////////////////////////////////////////////////////////
    // Play duration, saturating so a two-hour message never wraps
    always_ff @(posedge mclk_i) begin
        if (reset_i || state_r == ST_IDLE || state_r == ST_WAIT) begin
            dur_r <= '0;
        end else if (tick && dur_r != MAX_PLAY_MS) begin
            dur_r <= dur_r + 1'b1; // see R17
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Seizure and error flag
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            seize_r <= 1'b0;
        end else if (wr_cmd && wdata_i[CMD_SEIZE_BIT]) begin
            seize_r <= 1'b1; // see R1
        end else if (wr_cmd && wdata_i[CMD_UNSEIZE_BIT]) begin
            seize_r <= 1'b0;
        end
    end

    // A fresh bad pulse wins over a clear in the same cycle
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            bad_r <= 1'b0;
        end else if (qual_bad) begin
            bad_r <= 1'b1; // see R22
        end else if (wr_cmd && wdata_i[CMD_CLR_ERR_BIT]) begin
            bad_r <= 1'b0;
        end
    end

    assign tip_batt_o = seize_r; // see R1
    assign connect_o = state_r == ST_PLAY || state_r == ST_RESTART;
    assign ringback_o = state_r == ST_WAIT;
    assign disc_o = disc_r;
    assign icpt_o = icpt_r;

    ////////////////////////////////////////////////////////////////////
    // Read port
    always_comb begin
        stat.rep = rep_r;
        stat.state = state_r;
        stat.avail = avail;
        stat.answered = seize_r && loop_i; // see R2
        stat.seized = seize_r;
        stat.bad_pulse = bad_r;
        stat.connected = connect_o;
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i || !rd_i) begin
            rdata_r <= '0;
        end else if (addr_i == ADDR_CTRL) begin
            rdata_r <= DATA_W'(ctrl_r);
        end else if (addr_i == ADDR_STAT) begin
            rdata_r <= DATA_W'(stat);
        end else if (addr_i == ADDR_DUR) begin
            rdata_r <= DATA_W'(dur_r);
        end else begin
            rdata_r <= '0;
        end
    end

    assign rdata_o = rdata_r;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    chk_seize_polarity: assert property ( // see R1
        wr_cmd && wdata_i[CMD_SEIZE_BIT] |=> tip_batt_o)
        else $error("seizure did not apply battery to tip");

    chk_start_in_cont: assert property ( // see R8
        cont |-> ##1 !trunk_ctl_oe_o)
        else $error("start line driven in continuous mode");

    chk_cont_cut: assert property ( // see R5
        cont && state_r == ST_WAIT && qual_ok && avail && !rel_cmd
        |=> connect_o && !ringback_o)
        else $error("end pulse did not cut through waiting call");

    chk_barge_join: assert property ( // see R6
        state_r == ST_IDLE && req_cmd && !rel_cmd && ctrl_r.barge && avail
        |=> connect_o)
        else $error("barge-in call not connected at once");

    chk_rep_force: assert property ( // see R19
        state_r == ST_PLAY && qual_ok && rep_last && !rel_cmd
        |=> (disc_o ^ icpt_o) && state_r == ST_IDLE ##1 !disc_o && !icpt_o)
        else $error("repeat limit did not force release");

    chk_level_hold: assert property ( // see R11
        (lvl && state_r == ST_PLAY && timer_r == '0 && !kick) [*2]
        |-> trunk_ctl_oe_o)
        else $error("level start dropped during play");

    chk_level_drop: assert property ( // see R12
        $fell(connect_o) && lvl |-> ##[0:1] !trunk_ctl_oe_o)
        else $error("level start held after call left");

    chk_dur_bound: assert property ( // see R17
        dur_r <= MAX_PLAY_MS)
        else $error("play duration overran its ceiling");

    chk_mode_legal: assert property ( // see R21
        ctrl_r.mode != MODE_RSVD)
        else $error("reserved announcer mode accepted");

    chk_read_late: assert property (
        rd_i && addr_i == ADDR_DUR |=> rdata_o == DATA_W'($past(dur_r)))
        else $error("read data not returned next cycle");

    cov_cont_call: cover property (
        state_r == ST_WAIT ##1 state_r == ST_PLAY && cont);
    cov_pulse_repeat: cover property (
        state_r == ST_RESTART ##[1:1000] state_r == ST_PLAY);
    cov_force_disc: cover property (disc_o);
    cov_intercept: cover property (icpt_o);

endmodule : announcement_trunk_control

//--- testbench/announcer_model.sv
// Behavioural announcer channel facing one trunk unit
`timescale 1ns/1ps
module announcer_model
    import ann_trunk_pkg::*;
#(
    parameter int TICK = 4,
    parameter int MSG_MS = 400
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Set-up from the bench
    input wire mode_t mode_i,
    input wire logic gnd_play_i,
    input wire logic online_i,
    input wire logic [PW_W-1:0] pw_ms_i,
    // Lines toward the trunk, 1 = ground
    input wire logic start_gnd_i,
    output logic avail_gnd_o,
    output logic msg_gnd_o
);
    localparam int MSG_C = MSG_MS * TICK;
    int pos;
    int pw_c;
    logic busy_r;
    logic start_d_r;
    logic act;
    logic cut;
    mode_t mode_d_r;

    ////////////////////////////////////////////////////////////////////
    assign pw_c = int'(pw_ms_i) * TICK;
    assign cut = mode_i == MODE_LEVEL && !start_gnd_i && pos < MSG_C;
    // A mode change drops the message, so no half message leaks across
    always_ff @(posedge mclk_i) begin
        start_d_r <= start_gnd_i;
        mode_d_r <= mode_i;
        if (reset_i || !online_i || mode_i != mode_d_r) begin
            busy_r <= 1'b0;
            pos <= 0;
        end else if (mode_i == MODE_CONT) begin
            busy_r <= 1'b1;
            pos <= (pos >= MSG_C + pw_c - 1) ? 0 : pos + 1;
        end else if (!busy_r) begin
            busy_r <= start_gnd_i && !start_d_r;
            pos <= 0;
        end else if (cut) begin
            busy_r <= 1'b0;
        end else if (pos >= MSG_C + pw_c - 1) begin
            busy_r <= 1'b0;
        end else begin
            pos <= pos + 1; // Starts while busy are ignored
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign act = busy_r && ((mode_i != MODE_CONT && pos < pw_c)
                 || pos >= MSG_C);
    assign msg_gnd_o = gnd_play_i ? act : !act;
    assign avail_gnd_o = online_i && mode_i == MODE_CONT;
endmodule : announcer_model

//--- testbench/announcement_trunk_control_tb_top.sv
// Self-checking bench for the announcement trunk unit
`timescale 1ns/1ps
module announcement_trunk_control_tb_top;
    import ann_trunk_pkg::*;

    localparam int TICK = 4;
    typedef struct packed {
        logic wr;
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d;
        logic [DATA_W-1:0] m;
    } row_t;

    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DATA_W-1:0] wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic loop_i = 1'b0;
    logic [DATA_W-1:0] rdata_o;
    logic trunk_ctl_i, trunk_ctl_o, trunk_ctl_oe_o;
    logic msg_gnd_i, tip_batt_o, avail;
    logic connect_o, ringback_o, disc_o, icpt_o;
    mode_t amode = MODE_CONT;
    logic gplay = 1'b0;
    logic online = 1'b1;
    logic [PW_W-1:0] pw = PULSE_NOM_MS;
    logic act_d = 1'b0;
    logic [DATA_W-1:0] rd_v;
    ctrl_t c;
    int errors = 0;
    int compares = 0;
    int n;
    int ends = 0;
    row_t rows [8] = '{
        '{1'b0, ADDR_CTRL, 32'h0c0, '1},
        '{1'b0, ADDR_DUR, 32'h0, '1},
        '{1'b0, ADDR_STAT, 32'h0, 32'h6f},
        '{1'b1, ADDR_CTRL, 32'h0c3, '0},
        '{1'b0, ADDR_CTRL, 32'h0c0, '1},
        '{1'b1, 4'h2, 32'hff, '0},
        '{1'b0, 4'h2, 32'h0, '1},
        '{1'b0, 4'h3, 32'h0, '1}};

    ////////////////////////////////////////////////////////////////////
    announcement_trunk_control #(.TICK_CYCLES(TICK)) dut (
        .mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .trunk_ctl_i(trunk_ctl_i), .trunk_ctl_o(trunk_ctl_o),
        .trunk_ctl_oe_o(trunk_ctl_oe_o),
        .msg_gnd_i(msg_gnd_i), .loop_i(loop_i), .tip_batt_o(tip_batt_o),
        .connect_o(connect_o), .ringback_o(ringback_o),
        .disc_o(disc_o), .icpt_o(icpt_o));
    announcer_model #(.TICK(TICK), .MSG_MS(400)) ann (
        .mclk_i(mclk_i), .reset_i(reset_i), .mode_i(amode),
        .gnd_play_i(gplay), .online_i(online), .pw_ms_i(pw),
        .start_gnd_i(trunk_ctl_oe_o & trunk_ctl_o),
        .avail_gnd_o(avail),
        .msg_gnd_o(msg_gnd_i));
    // Wired line: either party may ground it
    assign trunk_ctl_i = (trunk_ctl_oe_o & trunk_ctl_o) | avail;

    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end
    // Message pulse ends seen on the line
    always @(posedge mclk_i) begin
        act_d <= gplay ~^ msg_gnd_i;
        if (act_d && !(gplay ~^ msg_gnd_i)) begin
            ends <= ends + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp,
               input string what);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : reg_wr

    task reg_rd(input logic [ADDR_W-1:0] a);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 rd_v = rdata_o;
    endtask : reg_rd

    task set_ctrl(input ctrl_t v);
        reg_wr(ADDR_CTRL, DATA_W'(v));
        amode <= v.mode;
        gplay <= v.gnd_play;
    endtask : set_ctrl

    function automatic logic pick(input int sel);
        case (sel)
            0: return connect_o === 1'b1;
            1: return (disc_o | icpt_o) === 1'b1;
            2: return trunk_ctl_oe_o === 1'b1;
            default: return trunk_ctl_oe_o === 1'b0;
        endcase
    endfunction : pick

    // Bounded wait; n holds the cycles spent
    task wait_for(input int sel, input int lim);
        n = 0;
        do begin
            @(posedge mclk_i);
            #1;
            n++;
        end while (!pick(sel) && n < lim);
    endtask : wait_for

    task results();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    initial begin
        repeat (60000) @(posedge mclk_i);
        errors++;
        results();
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge mclk_i);
        reset_i <= 1'b0;
        #1 check(32'(trunk_ctl_oe_o | tip_batt_o | connect_o), 0,
                 "reset outs");
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                reg_wr(rows[i].a, rows[i].d);
            end else begin
                reg_rd(rows[i].a);
                check(rd_v & rows[i].m, rows[i].d, "register");
            end
        end
        reg_wr(ADDR_CMD, 32'h4);
        #1 check(32'(tip_batt_o), 1, "tip battery");
        loop_i <= 1'b1;
        reg_rd(ADDR_STAT);
        check(rd_v & 32'hc, 32'hc, "answered");
        reg_wr(ADDR_CMD, 32'h8);
        loop_i <= 1'b0;
        #1 check(32'(tip_batt_o), 0, "tip released");
        // Continuous: ringback, cut-through, repeats to disconnect, then to intercept
        for (int k = 0; k < 2; k++) begin
            c = CTRL_RST;
            c.rep_limit = 4'(k + 1);
            c.icpt_ok = 1'(k);
            set_ctrl(c);
            reg_wr(ADDR_CMD, 32'h1);
            #1 check(32'(ringback_o), 1, "ringback");
            wait_for(0, 4000);
            check(32'(connect_o & !ringback_o), 1, "cut through");
            ends = 0;
            wait_for(1, 12000);
            check(ends, k + 1, "repeats");
            check(32'(icpt_o), 32'(k), "intercept");
            @(posedge mclk_i);
            #1 check(32'(connect_o), 0, "forced release");
        end
        c = CTRL_RST;
        c.barge = 1'b1;
        set_ctrl(c);
        online <= 1'b0;
        reg_wr(ADDR_CMD, 32'h1);
        repeat (20) @(posedge mclk_i);
        #1 check(32'(connect_o), 0, "unavailable");
        online <= 1'b1;
        reg_wr(ADDR_CMD, 32'h2);
        reg_wr(ADDR_CMD, 32'h1);
        wait_for(0, 8);
        check(32'(connect_o), 1, "barge in");
        reg_wr(ADDR_CMD, 32'h3);
        #1 check(32'(connect_o | ringback_o), 0, "release");
        // Short pulses are refused; ground-active line then works
        c = CTRL_RST;
        c.gnd_play = 1'b1;
        set_ctrl(c);
        pw <= 9'd150;
        reg_wr(ADDR_CMD, 32'h1);
        wait_for(0, 3000);
        check(32'(connect_o), 0, "short pulse");
        reg_rd(ADDR_STAT);
        check(rd_v & 32'h2, 32'h2, "bad pulse");
        pw <= PULSE_NOM_MS;
        reg_wr(ADDR_CMD, 32'h10);
        reg_rd(ADDR_STAT);
        check(rd_v & 32'h2, 0, "flag cleared");
        wait_for(0, 4000);
        check(32'(connect_o), 1, "ground play");
        reg_wr(ADDR_CMD, 32'h2);
        // Pulse start
        c = CTRL_RST;
        c.mode = MODE_PULSE;
        c.rep_limit = 4'h2;
        set_ctrl(c);
        reg_wr(ADDR_CMD, 32'h1);
        wait_for(2, 8);
        check(32'(trunk_ctl_o), 1, "start drive");
        wait_for(3, 1100);
        check(32'(n >= 997 && n <= 1000), 1, "start width");
        wait_for(0, 200);
        check(32'(connect_o), 1, "start pulse");
        wait_for(1, 6000);
        check(32'(disc_o), 1, "message end");
        // Level start
        c.mode = MODE_LEVEL;
        set_ctrl(c);
        reg_wr(ADDR_CMD, 32'h1);
        wait_for(2, 60);
        check(32'(n >= 38 && n <= 46), 1, "level gap");
        wait_for(0, 1500);
        check(32'(trunk_ctl_oe_o & connect_o), 1, "level held");
        wait_for(1, 6000);
        repeat (2) @(posedge mclk_i);
        #1 check(32'(trunk_ctl_oe_o), 0, "level dropped");
        // Reset in mid-call
        reg_wr(ADDR_CMD, 32'h5);
        repeat (100) @(posedge mclk_i);
        reset_i <= 1'b1;
        repeat (10) @(posedge mclk_i);
        #1 check(32'({trunk_ctl_oe_o, tip_batt_o, ringback_o}), 0, "reset 2");
        reset_i <= 1'b0;
        reg_rd(ADDR_CTRL);
        check(rd_v, 32'h0c0, "ctrl after reset");
        results();
    end
endmodule : announcement_trunk_control_tb_top
